/* src/bus_timing_pkg.sv */
// constants, decode codes and state type for the bus cycle timing block
// assumes a 100 MHz mclk; all timing counts derive from its period
package bus_timing_pkg;

  localparam int CLK_NS          = 10;
  localparam int CPU_CLK_NS      = 100;
  localparam int FAST_CYCLE_NS   = 400;
  localparam int DMA_CYCLE_NS    = 500;
  localparam int ACK_LEAD_NS     = 100;
  localparam int SLOW_EXTRA_CLKS = 6;
  localparam int FAST_ACK_CYC    = (ACK_LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOW_ACK_CYC    = FAST_ACK_CYC + (SLOW_EXTRA_CLKS * CPU_CLK_NS) / CLK_NS;
  localparam int DMA_ACK_CYC     = FAST_ACK_CYC + (DMA_CYCLE_NS - FAST_CYCLE_NS) / CLK_NS;
  localparam int TIMER_W         = 8;

  localparam int POWERUP_MS      = 100;
  localparam int POWERUP_CYC     = (POWERUP_MS * 1000000) / CLK_NS;
  localparam int RESET_W         = 24;
  localparam int SW_RESET_CLKS   = 124;
  localparam int SW_RESET_CYC    = (SW_RESET_CLKS * CPU_CLK_NS) / CLK_NS;
  localparam int SW_W            = 11;

  localparam int CLK_1M_DIV      = 10;

  localparam logic [1:0] REGION_RAM     = 2'h0;
  localparam logic [1:0] REGION_FAST_IO = 2'h1;
  localparam logic [1:0] REGION_ROM     = 2'h2;
  localparam logic [1:0] REGION_SLOW_IO = 2'h3;

  localparam logic [2:0] FC_CPU_SPACE   = 3'h7;
  localparam int         FC_SUPER_BIT   = 2;
  localparam int         IRQ_W          = 3;

  // request index order is the priority order, 0 highest
  localparam int DMA_MASTERS     = 5;
  localparam int DMA_DISK        = 0;
  localparam int DMA_REFRESH     = 1;
  localparam int DMA_EXP2        = 2;
  localparam int DMA_EXP1        = 3;
  localparam int DMA_EXP0        = 4;

  typedef enum logic [1:0] {st_idle, st_count, st_done} bus_state_e;

endpackage

/* src/clock_divider.sv */
// board clock divider: 40 MHz source down to 20, 10, 5 and 1 MHz
// assumes osc_40m is sampled synchronously to mclk
`timescale 1ns/1ps
module clock_divider #(
  parameter int ONE_MHZ_DIV = bus_timing_pkg::CLK_1M_DIV
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic osc_40m,
  output logic      clock_20m,
  output logic      cpu_clock_10m,
  output logic      cpu_clock_phase,
  output logic      clock_5m,
  output logic      clock_1m
);
  import bus_timing_pkg::*;

  localparam int HALF = ONE_MHZ_DIV / 2;

  if (ONE_MHZ_DIV < 2 || ONE_MHZ_DIV % 2 != 0 || ONE_MHZ_DIV > 32) begin : g_chk
    $error("ONE_MHZ_DIV must be even, 2..32");
  end

  logic       osc_q;
  logic [4:0] div_cnt;

  wire osc_rise = osc_40m && !osc_q;
  wire fall_20  = osc_rise && clock_20m;
  wire fall_10  = fall_20 && cpu_clock_10m;
  wire rise_10  = fall_20 && !cpu_clock_10m;
  wire half_end = rise_10 && (div_cnt == 5'(HALF - 1));

  ////////////////////////////////////////////////////////////////////////
  // RQ13: flip-flop division chain
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      osc_q           <= 1'b0;
      clock_20m       <= 1'b0;
      cpu_clock_10m   <= 1'b0;
      cpu_clock_phase <= 1'b1;
    end else begin
      osc_q <= osc_40m;
      if (osc_rise) begin
        clock_20m <= !clock_20m;
      end
      // RQ12: even-duty processor clock
      if (fall_20) begin
        cpu_clock_10m   <= !cpu_clock_10m;
        cpu_clock_phase <= cpu_clock_10m;
      end
    end
  end

  // RQ14: 5 MHz and 1 MHz from processor clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clock_5m <= 1'b0;
      clock_1m <= 1'b0;
      div_cnt  <= 5'h00;
    end else begin
      if (fall_10) begin
        clock_5m <= !clock_5m;
      end
      if (half_end) begin
        clock_1m <= !clock_1m;
        div_cnt  <= 5'h00;
      end else if (rise_10) begin
        div_cnt <= div_cnt + 5'h01;
      end
    end
  end

  a_phase_inverse: assert property (@(posedge mclk) disable iff (!nrst) // RQ12
    cpu_clock_phase == !cpu_clock_10m) else $error("processor clock phase not inverse");

endmodule

/* src/cpu_bus_cycle_timing.sv */
// board bus cycle timing, decode, arbitration, interrupt and reset logic
// assumes all inputs synchronous to mclk; reset and halt are open-drain lines
//
// Functional notes
// RQ1: top bits 00 is RAM, fast, any state
// RQ2: top bits 01 is fast I/O, supervisor only
// RQ3: top bits 10 is ROM, slow read, supervisor
// RQ4: top bits 11 is slow I/O, supervisor only
// RQ5: fast 400 ns, slow 1000 ns by decode
// RQ6: slow cycles delay acknowledge six processor clocks
// RQ7: DMA cycles fast, 500 ns incl arbitration
// RQ8: processor fast cycle is eight half-clock states
// RQ9: processor samples acknowledge at end of state four
// RQ10: processor adds wait states until acknowledge
// RQ11: read data latched one clock after acknowledge
// RQ12: processor clock 10 MHz, even duty
// RQ13: 40 MHz divided to 20 and 10 MHz
// RQ14: 5 MHz and 1 MHz from processor clock
// RQ15: one DMA grant at a time, else processor
// RQ16: processor buffers drive bus, DMA floated
// RQ17: DMA drivers on bus, processor buffers floated
// RQ18: DMA limited to RAM quarter of space
// RQ19: encoded interrupt level held until acknowledged
// RQ20: autovector request on every interrupt acknowledge
// RQ21: processor function code gives state and cycle
// RQ22: power-up reset 100 ms, software reset 124 clocks
// RQ23: request, grant, acknowledge latches, release ends
// RQ24: priority disk, refresh, boards 2, 1, 0
// RQ25: user access to supervisor region gets fault
`timescale 1ns/1ps
module cpu_bus_cycle_timing #(
  parameter int DMA_MASTERS    = bus_timing_pkg::DMA_MASTERS,
  parameter int POWERUP_CYCLES = bus_timing_pkg::POWERUP_CYC
) (
  input  wire logic                            mclk,
  input  wire logic                            nrst,
  input  wire logic                            osc_40m,
  input  wire logic [1:0]                      addr_top,
  input  wire logic                            addr_strobe_n,
  input  wire logic                            upper_byte_strobe_n,
  input  wire logic                            lower_byte_strobe_n,
  input  wire logic                            cpu_read,
  input  wire logic [2:0]                      cycle_function_code,
  input  wire logic [1:0]                      dma_addr_top,
  input  wire logic                            dma_strobe_n,
  input  wire logic [DMA_MASTERS-1:0]          dma_req_n,
  input  wire logic                            grant_acknowledge_n,
  input  wire logic [7:1]                      irq_req,
  input  wire logic                            sw_reset_req,
  input  wire logic                            reset_line_in,
  output logic                                 transfer_ack_n,
  output logic                                 bus_fault_n,
  output logic                                 autovector_request_n,
  output logic [bus_timing_pkg::IRQ_W-1:0]     irq_level_code,
  output logic [DMA_MASTERS-1:0]               dma_grant_n,
  output logic                                 cpu_buf_oe_n,
  output logic                                 dma_buf_oe_n,
  output logic                                 reset_line_out,
  output logic                                 reset_line_oe_n,
  output logic                                 halt_line_out,
  output logic                                 halt_line_oe_n,
  output logic                                 clock_20m,
  output logic                                 cpu_clock_10m,
  output logic                                 cpu_clock_phase,
  output logic                                 clock_5m,
  output logic                                 clock_1m
);
  import bus_timing_pkg::*;

  if (DMA_MASTERS < 1 || DMA_MASTERS > 8) begin : g_chk_dma
    $error("DMA_MASTERS must be 1..8");
  end
  if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= (1 << RESET_W)) begin : g_chk_por
    $error("POWERUP_CYCLES out of counter range");
  end

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [DMA_MASTERS-1:0] first_req(input logic [DMA_MASTERS-1:0] req);
    logic found;
    found     = 1'b0;
    first_req = '0;
    for (int i = 0; i < DMA_MASTERS; i++) begin
      if (req[i] && !found) begin
        first_req[i] = 1'b1;
        found        = 1'b1;
      end
    end
  endfunction

  function automatic logic [IRQ_W-1:0] top_level(input logic [7:1] req);
    top_level = '0;
    for (int i = 1; i <= 7; i++) begin
      if (req[i]) begin
        top_level = IRQ_W'(i);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // clocks

  clock_divider u_clk (
    .mclk            (mclk),
    .nrst            (nrst),
    .osc_40m         (osc_40m),
    .clock_20m       (clock_20m),
    .cpu_clock_10m   (cpu_clock_10m),
    .cpu_clock_phase (cpu_clock_phase),
    .clock_5m        (clock_5m),
    .clock_1m        (clock_1m)
  );

  ////////////////////////////////////////////////////////////////////////
  // ownership and cycle decode

  bus_state_e               state;
  bus_state_e               next_state;
  logic [TIMER_W-1:0]       cnt;
  logic [TIMER_W-1:0]       k_delay;
  logic                     k_fault;
  logic                     k_iack;
  logic                     locked;

  wire [DMA_MASTERS-1:0] grant      = ~dma_grant_n;
  wire [DMA_MASTERS-1:0] pick       = first_req(~dma_req_n);
  wire                   dma_active = !grant_acknowledge_n;
  // RQ15: processor owns bus when no DMA grant and no acknowledge
  wire                   cpu_owner  = (grant == '0) && grant_acknowledge_n;
  wire                   cpu_strobe = !addr_strobe_n
                                      && (!upper_byte_strobe_n || !lower_byte_strobe_n);
  wire                   strobe     = dma_active ? !dma_strobe_n : (cpu_owner && cpu_strobe);
  wire                   start      = (state == st_idle) && strobe && reset_line_in;
  wire [1:0]             region     = dma_active ? dma_addr_top : addr_top;
  wire                   supervisor = cycle_function_code[FC_SUPER_BIT];
  // RQ20: function code all ones marks interrupt acknowledge
  wire                   is_iack    = !dma_active && (cycle_function_code == FC_CPU_SPACE);
  // RQ2: fast I/O supervisor only
  // RQ4: slow I/O supervisor only
  // RQ1: RAM open to either state
  wire                   user_bad   = !supervisor && (region != REGION_RAM);
  // RQ3: ROM is read only
  wire                   rom_write  = (region == REGION_ROM) && !cpu_read;
  // RQ18: DMA outside RAM quarter refused
  // RQ25: user access to supervisor region refused
  wire                   refused    = dma_active ? (region != REGION_RAM)
                                                 : (!is_iack && (user_bad || rom_write));
  // RQ5: cycle length chosen by top address bit
  // RQ7: DMA cycles get the arbitration allowance
  wire [TIMER_W-1:0]     delay_sel  = dma_active ? TIMER_W'(DMA_ACK_CYC - 1)
                                    : (refused || is_iack || !region[1])
                                      ? TIMER_W'(FAST_ACK_CYC - 1)
                                      : TIMER_W'(SLOW_ACK_CYC - 1);
  wire                   answer     = (next_state == st_done);
  wire                   iack_evt   = (state == st_count) && answer && k_iack;

  ////////////////////////////////////////////////////////////////////////
  // cycle timer

  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (start) begin
          next_state = st_count;
        end
      end
      st_count: begin
        if (!strobe || !reset_line_in) begin
          next_state = st_idle;
        end else if (cnt == k_delay) begin
          next_state = st_done;
        end
      end
      st_done: begin
        if (!strobe) begin
          next_state = st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state   <= st_idle;
      cnt     <= '0;
      k_delay <= '0;
      k_fault <= 1'b0;
      k_iack  <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= (state == st_count) ? cnt + 1'b1 : '0;
      if (start) begin
        k_delay <= delay_sel;
        k_fault <= refused;
        k_iack  <= is_iack;
      end
    end
  end

  // RQ6: slow answer six processor clocks later
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      transfer_ack_n       <= 1'b1;
      bus_fault_n          <= 1'b1;
      autovector_request_n <= 1'b1;
    end else begin
      transfer_ack_n       <= !(answer && !k_fault && !k_iack);
      bus_fault_n          <= !(answer && k_fault);
      autovector_request_n <= !(answer && k_iack);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // arbiter and bus drivers

  // RQ23: acknowledge latches grant, release drops it
  // RQ24: lowest index wins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dma_grant_n <= '1;
      locked      <= 1'b0;
    end else if (locked && grant_acknowledge_n) begin
      dma_grant_n <= '1;
      locked      <= 1'b0;
    end else if ((grant != '0) && dma_active) begin
      locked <= 1'b1;
    end else if (cpu_owner && (state == st_idle) && !start) begin
      dma_grant_n <= ~pick;
    end
  end

  // RQ16: processor buffers only while it owns the bus
  // RQ17: DMA drivers only while acknowledge held
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cpu_buf_oe_n <= 1'b1;
      dma_buf_oe_n <= 1'b1;
    end else begin
      cpu_buf_oe_n <= !cpu_owner;
      dma_buf_oe_n <= !dma_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt level

  // RQ19: code reloads only when idle or acknowledged
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_level_code <= '0;
    end else if ((irq_level_code == '0) || iack_evt) begin
      irq_level_code <= top_level(irq_req);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset generator

  logic [RESET_W-1:0] por_cnt;
  logic               por_done;
  logic [SW_W-1:0]    sw_cnt;

  wire             next_por  = por_done || (por_cnt == RESET_W'(POWERUP_CYCLES - 1));
  wire             sw_load   = por_done && sw_reset_req && (sw_cnt == '0);
  wire [SW_W-1:0]  next_sw   = sw_load ? SW_W'(SW_RESET_CYC)
                             : (sw_cnt != '0) ? sw_cnt - 1'b1 : '0;

  // RQ22: power-up and software reset lengths
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      por_cnt         <= '0;
      por_done        <= 1'b0;
      sw_cnt          <= '0;
      reset_line_out  <= 1'b0;
      halt_line_out   <= 1'b0;
      reset_line_oe_n <= 1'b0;
      halt_line_oe_n  <= 1'b0;
    end else begin
      por_cnt         <= next_por ? por_cnt : por_cnt + 1'b1;
      por_done        <= next_por;
      sw_cnt          <= next_sw;
      reset_line_oe_n <= next_por && (next_sw == '0);
      halt_line_oe_n  <= next_por;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  wire cpu_start = start && !dma_active && !refused && !is_iack;

  a_fast_ack_time: assert property ( // RQ5
    (cpu_start && !region[1]) |-> ##1 transfer_ack_n[*8] ##3
      (!transfer_ack_n || state == st_idle)) else $error("fast acknowledge mistimed");

  a_slow_ack_time: assert property ( // RQ6
    (cpu_start && region[1]) |-> ##1 transfer_ack_n[*8] ##63
      (!transfer_ack_n || state == st_idle)) else $error("slow acknowledge mistimed");

  a_dma_ack_time: assert property ( // RQ7
    (start && dma_active && !refused) |-> ##21 (!transfer_ack_n || state == st_idle))
    else $error("DMA acknowledge mistimed");

  a_user_fault: assert property ( // RQ25
    (start && !dma_active && user_bad && !is_iack) |-> ##1 bus_fault_n[*8] ##3
      (transfer_ack_n && (!bus_fault_n || state == st_idle))) else $error("user fault missed");

  a_dma_ram_only: assert property ( // RQ18
    (start && dma_active && region != REGION_RAM) |-> ##21
      (transfer_ack_n && (!bus_fault_n || state == st_idle))) else $error("DMA outside RAM");

  a_iack_autovec: assert property ( // RQ20
    (start && is_iack) |-> ##11
      (transfer_ack_n && (!autovector_request_n || state == st_idle)))
    else $error("autovector missing");

  a_single_grant: assert property ( // RQ15
    $onehot0(grant)) else $error("more than one grant");

  a_grant_priority: assert property ( // RQ24
    ($past(grant) == '0 && grant != '0) |-> grant == $past(pick))
    else $error("grant not highest request");

  a_buf_exclusive: assert property ( // RQ17
    !grant_acknowledge_n |=> (!dma_buf_oe_n && cpu_buf_oe_n)) else $error("DMA drivers off");

  a_irq_stable: assert property ( // RQ19
    (irq_level_code != '0 && !iack_evt) |=> $stable(irq_level_code))
    else $error("interrupt level changed early");

  a_sw_reset_len: assert property ( // RQ22
    sw_load |=> (!reset_line_oe_n && sw_cnt == SW_W'(SW_RESET_CYC))) else $error("reset start");

  a_sw_reset_end: assert property ( // RQ22
    (sw_cnt == SW_W'(1) && por_done) |=> reset_line_oe_n) else $error("software reset end");

endmodule

/* sim/cpu_master_model.sv */
// processor bus master model driving the bus cycle timing block
// assumes the bench calls run at any time; strobes change at falling mclk
`timescale 1ns/1ps
module cpu_master_model (
  input  wire logic  mclk,
  input  wire logic  transfer_ack_n,
  input  wire logic  bus_fault_n,
  input  wire logic  autovector_request_n,
  output logic [1:0] addr_top,
  output logic       addr_strobe_n,
  output logic       upper_byte_strobe_n,
  output logic       lower_byte_strobe_n,
  output logic       cpu_read,
  output logic [2:0] cycle_function_code
);
  initial begin
    addr_top = 2'h0;
    addr_strobe_n = 1'b1;
    upper_byte_strobe_n = 1'b1;
    lower_byte_strobe_n = 1'b1;
    cpu_read = 1'b1;
    cycle_function_code = 3'h0;
  end

  task automatic run(input logic [1:0] a, input logic [2:0] fc, input logic rd,
                     output logic [1:0] kind, output int lat);
    lat = 0;
    kind = 2'h3;
    @(negedge mclk);
    addr_top = a;
    cycle_function_code = fc;
    cpu_read = rd;
    addr_strobe_n = 1'b0;
    upper_byte_strobe_n = ~rd;
    lower_byte_strobe_n = 1'b0;
    while (kind == 2'h3 && lat < 200) begin
      @(negedge mclk);
      lat++;
      if (transfer_ack_n === 1'b0) kind = 2'h0;
      else if (bus_fault_n === 1'b0) kind = 2'h1;
      else if (autovector_request_n === 1'b0) kind = 2'h2;
    end
    // read data taken a clock later
    if (rd) repeat (10) @(negedge mclk);
    addr_strobe_n = 1'b1;
    upper_byte_strobe_n = 1'b1;
    lower_byte_strobe_n = 1'b1;
    addr_top = ~a;
    cycle_function_code = ~fc;
    repeat (2) @(negedge mclk);
  endtask
endmodule

/* sim/cpu_bus_cycle_timing_test.sv */
// self-checking bench for the bus cycle timing block
// assumes the processor model beside it; DMA masters are driven here
`timescale 1ns/1ps
module cpu_bus_cycle_timing_test;
  import bus_timing_pkg::*;
  logic       mclk, nrst, osc_40m, sw_reset_req, dma_strobe_n, grant_acknowledge_n;
  logic [1:0] addr_top, dma_addr_top;
  logic       addr_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, cpu_read;
  logic [2:0] cycle_function_code, irq_level_code;
  logic [4:0] dma_req_n, dma_grant_n;
  logic [7:1] irq_req;
  logic       transfer_ack_n, bus_fault_n, autovector_request_n, cpu_buf_oe_n;
  logic       dma_buf_oe_n, reset_line_out, reset_line_oe_n, halt_line_out;
  logic       halt_line_oe_n, clock_20m, cpu_clock_10m, cpu_clock_phase;
  logic       clock_5m, clock_1m;
  wire logic  reset_line_in;
  logic [3:0] clks;
  int         error_cnt, checks_done, cyc;

  // pulled-up open-drain reset line
  assign reset_line_in = reset_line_oe_n ? 1'b1 : reset_line_out;
  assign clks = {clock_1m, clock_5m, cpu_clock_10m, clock_20m};

  cpu_bus_cycle_timing #(.DMA_MASTERS(5), .POWERUP_CYCLES(50)) uut (
    .mclk(mclk), .nrst(nrst), .osc_40m(osc_40m), .addr_top(addr_top),
    .addr_strobe_n(addr_strobe_n), .upper_byte_strobe_n(upper_byte_strobe_n),
    .lower_byte_strobe_n(lower_byte_strobe_n), .cpu_read(cpu_read),
    .cycle_function_code(cycle_function_code), .dma_addr_top(dma_addr_top),
    .dma_strobe_n(dma_strobe_n), .dma_req_n(dma_req_n),
    .grant_acknowledge_n(grant_acknowledge_n), .irq_req(irq_req),
    .sw_reset_req(sw_reset_req), .reset_line_in(reset_line_in),
    .transfer_ack_n(transfer_ack_n), .bus_fault_n(bus_fault_n),
    .autovector_request_n(autovector_request_n), .irq_level_code(irq_level_code),
    .dma_grant_n(dma_grant_n), .cpu_buf_oe_n(cpu_buf_oe_n), .dma_buf_oe_n(dma_buf_oe_n),
    .reset_line_out(reset_line_out), .reset_line_oe_n(reset_line_oe_n),
    .halt_line_out(halt_line_out), .halt_line_oe_n(halt_line_oe_n),
    .clock_20m(clock_20m), .cpu_clock_10m(cpu_clock_10m),
    .cpu_clock_phase(cpu_clock_phase), .clock_5m(clock_5m), .clock_1m(clock_1m));

  cpu_master_model cpu (
    .mclk(mclk), .transfer_ack_n(transfer_ack_n), .bus_fault_n(bus_fault_n),
    .autovector_request_n(autovector_request_n), .addr_top(addr_top),
    .addr_strobe_n(addr_strobe_n), .upper_byte_strobe_n(upper_byte_strobe_n),
    .lower_byte_strobe_n(lower_byte_strobe_n), .cpu_read(cpu_read),
    .cycle_function_code(cycle_function_code));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    forever begin
      repeat (2) @(negedge mclk);
      osc_40m = ~osc_40m;
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  function automatic logic quiet();
    return transfer_ack_n === 1'b1 && bus_fault_n === 1'b1 && autovector_request_n === 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    int  n;
    logic same;
    n = 0;
    same = 1'b1;
    while (reset_line_oe_n === 1'b0 && n < 100) begin
      same &= (halt_line_oe_n === 1'b0) && (reset_line_out === 1'b0)
              && (halt_line_out === 1'b0);
      @(negedge mclk);
      n++;
    end
    check(same && (n == 50 || n == 51), "power-up reset length");
    check(halt_line_oe_n === 1'b1, "halt released");
  endtask

  task automatic t_clocks();
    int per [4] = '{8, 16, 32, 160};
    int n;
    int h;
    for (int c = 0; c < 4; c++) begin
      n = 0;
      while (clks[c] !== 1'b0 && n < 400) begin @(negedge mclk); n++; end
      while (clks[c] !== 1'b1 && n < 400) begin @(negedge mclk); n++; end
      h = 0;
      while (clks[c] === 1'b1 && h < 400) begin @(negedge mclk); h++; end
      n = h;
      while (clks[c] === 1'b0 && n < 400) begin @(negedge mclk); n++; end
      check(n == per[c] && h * 2 == per[c], "clock period or duty");
    end
    check(cpu_clock_phase === ~cpu_clock_10m, "clock phase");
  endtask

  task automatic t_decode();
    logic [2:0] fcs [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
    logic [1:0] k;
    logic       rd;
    logic       ok;
    int         lat;
    for (int r = 0; r < 4; r++) begin
      for (int s = 0; s < 8; s++) begin
        rd = 1'(s % 2);
        ok = (r == 0) || (fcs[s/2][2] && !(r == 2 && !rd));
        cpu.run(2'(r), fcs[s/2], rd, k, lat);
        check(k === (ok ? 2'h0 : 2'h1), "region response");
        check(lat == ((ok && r >= 2) ? 71 : 11), "cycle length");
        check(quiet() && cpu_buf_oe_n === 1'b0 && dma_buf_oe_n === 1'b1, "cpu bus");
      end
    end
  endtask

  task automatic t_irq();
    logic [1:0] k;
    int         lat;
    for (int l = 1; l <= 7; l++) begin
      irq_req = 7'(1 << (l - 1));
      cpu.run(2'h3, FC_CPU_SPACE, 1'b1, k, lat);
      check(k === 2'h2 && lat == 11, "autovector answer");
      check(irq_level_code === 3'(l), "level code");
    end
    irq_req = 7'h02;
    repeat (5) @(negedge mclk);
    check(irq_level_code === 3'h7, "level held");
    cpu.run(2'h3, FC_CPU_SPACE, 1'b1, k, lat);
    check(irq_level_code === 3'h2, "level after ack");
    irq_req = 7'h00;
    cpu.run(2'h3, FC_CPU_SPACE, 1'b1, k, lat);
    check(irq_level_code === 3'h0, "no level");
  endtask

  task automatic dma_cycle(input logic [1:0] a);
    int n;
    dma_addr_top = a;
    dma_strobe_n = 1'b0;
    n = 0;
    while (quiet() && n < 100) begin @(negedge mclk); n++; end
    check(n == 21, "dma cycle length");
    if (a == 2'h0) check(transfer_ack_n === 1'b0 && bus_fault_n === 1'b1, "ram ok");
    else check(bus_fault_n === 1'b0 && transfer_ack_n === 1'b1, "dma out of ram");
    dma_strobe_n = 1'b1;
    dma_addr_top = ~a;
    repeat (2) @(negedge mclk);
    check(quiet(), "dma answer released");
  endtask

  task automatic t_arb();
    int n;
    dma_req_n = 5'h00;
    for (int i = 0; i < 5; i++) begin
      n = 0;
      while (dma_grant_n === 5'h1f && n < 20) begin @(negedge mclk); n++; end
      check(dma_grant_n === ~(5'h01 << i), "grant order");
      grant_acknowledge_n = 1'b0;
      dma_req_n[i] = 1'b1;
      repeat (2) @(negedge mclk);
      check(dma_buf_oe_n === 1'b0 && cpu_buf_oe_n === 1'b1, "dma drives bus");
      dma_cycle(2'h0);
      dma_cycle(2'(i % 3 + 1));
      check(dma_grant_n === ~(5'h01 << i), "grant latched");
      grant_acknowledge_n = 1'b1;
      repeat (2) @(negedge mclk);
      check(dma_grant_n[i] === 1'b1, "grant dropped");
    end
    repeat (3) @(negedge mclk);
    check(dma_grant_n === 5'h1f && cpu_buf_oe_n === 1'b0 && dma_buf_oe_n === 1'b1, "cpu back");
  endtask

  task automatic t_swreset();
    int  n;
    logic halt;
    sw_reset_req = 1'b1;
    @(negedge mclk);
    sw_reset_req = 1'b0;
    n = 0;
    while (reset_line_oe_n === 1'b1 && n < 10) begin @(negedge mclk); n++; end
    n = 0;
    halt = 1'b1;
    while (reset_line_oe_n === 1'b0 && n < 2000) begin
      halt &= (halt_line_oe_n === 1'b1);
      @(negedge mclk);
      n++;
    end
    check(n == 1240 && halt, "software reset length");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    nrst = 1'b0;
    osc_40m = 1'b0;
    sw_reset_req = 1'b0;
    dma_addr_top = 2'h0;
    dma_strobe_n = 1'b1;
    dma_req_n = 5'h1f;
    grant_acknowledge_n = 1'b1;
    irq_req = 7'h00;
    repeat (6) @(negedge mclk);
    check(quiet() && dma_grant_n === 5'h1f && irq_level_code === 3'h0, "reset outputs");
    check(reset_line_oe_n === 1'b0 && halt_line_oe_n === 1'b0, "reset driven");
    nrst = 1'b1;
    t_powerup();
    t_clocks();
    t_decode();
    t_irq();
    t_arb();
    t_swreset();
    complete_run();
  end
endmodule
